// ---- logic/apt_proc_end.sv ----
// processor end: master address tenure, parity generation, snoop check and error report
`timescale 1ns/10ps
`default_nettype none
`include "apt_cfg.svh"
// Function
// [RL1] check own-tag direct-store reply only
// [RL2] direct-store: strobe beat, next beat
// [RL3] byte plus parity bit odd
// [RL4] parity bit n covers byte n
// [RL5] parity, type track address drive
// [RL6] parity, type sampled with address
// [RL7] bad parity: checkstop or machine check
// [RL8] strict variant: always checkstop
// [RL9] error only for recognised snoops
// [RL10] strict variant: no error unchecked
// [RL11] error line pulls low only
// [RL12] error low second cycle after strobe
// [RL13] error released third cycle
// [RL14] type bit1 read, bit3 data
// [RL15] extended code: type, burst, size
// [RL16] strict variant: type bit4 negated
// [RL17] snoop type only with direct-store strobe
// [RL18] four codes are address-only
// [RL19] drive after grant, float after acknowledge
// [RL20] snoop address in strobe cycle
// [RL21] parity from driven address
module apt_proc_end (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // bus side
  apt_bus_if.proc bus,
  // master request
  input wire logic reqValid,
  input wire logic reqDirect,
  input wire logic [0:`APT_ADDR_W-1] reqAddr,
  input wire logic [0:`APT_ADDR_W-1] reqAddr2,
  input wire logic [0:`APT_TT_W-1] reqTt,
  input wire logic reqBurstN,
  input wire logic [0:`APT_SIZE_W-1] reqSize,
  output logic reqTaken,
  output logic tenureDone,
  // configuration
  input wire logic parityCheckEn,
  input wire logic machineCheckEnable,
  input wire logic strictVariant,
  input wire logic [0:`APT_TAG_W-1] processorTag,
  // snoop results
  output logic snoopValid,
  output logic snoopDirect,
  output logic snoopRead,
  output logic snoopAddrOnly,
  output logic [0:`APT_ADDR_W-1] snoopAddr,
  output logic [0:`APT_TT_W-1] snoopTt,
  output logic [0:`APT_EXTENDED_TRANSFER_CODE_W-1] snoopXatc,
  // error reporting
  output logic checkstop,
  output logic machineCheck
);
  apt_pkg::apt_mst_state_type mstState_q, mstState_d;
  logic latDirect_q, latDirect_d, latBurstN_q, latBurstN_d;
  logic [0:`APT_ADDR_W-1] latAddr2_q, latAddr2_d, drvAddr_q, drvAddr_d;
  logic [0:`APT_TT_W-1] latTt_q, latTt_d;
  logic [0:`APT_SIZE_W-1] latSize_q, latSize_d;
  logic [0:`APT_PAR_W-1] drvPar_q, drvPar_d, parBad;
  logic tsN_q, tsN_d, xatsN_q, xatsN_d, abbN_q, abbN_d, oe_q, oe_d;
  logic taken_q, taken_d, done_q, done_d;
  logic qualGrant, memHit, dsHit, detect, apeReq, excReq;
  logic [`APT_APE_ASSERT_DLY-1:0] apePipe_q, apePipe_d;
  logic excPend_q, excPend_d, checkstop_q, checkstop_d, mc_q, mc_d;
  logic snValid_q, snValid_d, snDirect_q, snDirect_d, snRead_q, snRead_d;
  logic snAddrOnly_q, snAddrOnly_d;
  logic [0:`APT_ADDR_W-1] snAddr_q, snAddr_d;
  logic [0:`APT_TT_W-1] snTt_q, snTt_d;
  logic [0:`APT_EXTENDED_TRANSFER_CODE_W-1] snXatc_q, snXatc_d;

  ////////////////////////////////////////////////////////////////////////////
  // per-byte odd parity out and parity check in
  genvar gi;
  generate
    for (gi = 0; gi < `APT_PAR_W; gi++) begin : gByte
      assign drvPar_d[gi] = ~^drvAddr_d[gi*`APT_BYTE_W +: `APT_BYTE_W]; // [RL3] [RL4] [RL21]
      assign parBad[gi] = ~^{bus.addressBus[gi*`APT_BYTE_W +: `APT_BYTE_W],
                             bus.addressByteParity[gi]}; // [RL3] [RL4]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // master tenure sequencing
  assign qualGrant = !bus.busGrantN && bus.addressBusyN && bus.memoryStartStrobeN &&
                     bus.directStoreStartStrobeN;

  always_comb begin
    mstState_d = mstState_q;
    latDirect_d = latDirect_q;
    latAddr2_d = latAddr2_q;
    latTt_d = latTt_q;
    latBurstN_d = latBurstN_q;
    latSize_d = latSize_q;
    drvAddr_d = drvAddr_q;
    tsN_d = 1'b1;
    xatsN_d = 1'b1;
    abbN_d = abbN_q;
    oe_d = oe_q;
    taken_d = 1'b0;
    done_d = 1'b0;
    case (mstState_q)
      apt_pkg::MST_IDLE: begin
        if (reqValid) begin
          // bus is floated here, so loading is invisible
          latDirect_d = reqDirect;
          drvAddr_d = reqAddr;
          latAddr2_d = reqAddr2;
          latTt_d = {reqTt[0:3], strictVariant ? `APT_TT4_NEGATED : reqTt[4]}; // [RL16]
          latBurstN_d = reqBurstN;
          latSize_d = reqSize;
          taken_d = 1'b1;
          mstState_d = apt_pkg::MST_WAIT;
        end
      end
      apt_pkg::MST_WAIT: begin
        if (qualGrant) begin
          oe_d = 1'b1; // [RL19] [RL5]
          abbN_d = 1'b0;
          tsN_d = latDirect_q;
          xatsN_d = !latDirect_q; // [RL2]
          mstState_d = apt_pkg::MST_BEAT1;
        end
      end
      apt_pkg::MST_BEAT1: begin
        if (latDirect_q) begin
          drvAddr_d = latAddr2_q; // [RL2]
          mstState_d = apt_pkg::MST_BEAT2;
        end else begin
          mstState_d = apt_pkg::MST_HOLD;
        end
      end
      apt_pkg::MST_BEAT2: begin
        mstState_d = apt_pkg::MST_HOLD;
      end
      apt_pkg::MST_HOLD: begin
        if (!bus.addressAcknowledgeN) begin
          oe_d = 1'b0; // [RL19] [RL5]
          abbN_d = 1'b1;
          done_d = 1'b1;
          mstState_d = apt_pkg::MST_IDLE;
        end
      end
      default: begin
        oe_d = 1'b0;
        abbN_d = 1'b1;
        mstState_d = apt_pkg::MST_IDLE;
      end
    endcase
  end

  // master state registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mstState_q <= apt_pkg::MST_IDLE;
      {latDirect_q, latTt_q, latSize_q, oe_q, taken_q, done_q} <= '0;
      {latBurstN_q, drvPar_q, tsN_q, xatsN_q, abbN_q} <= '1;
      {latAddr2_q, drvAddr_q} <= {2{`APT_ADDR_RST}};
    end else begin
      mstState_q <= mstState_d;
      latDirect_q <= latDirect_d;
      latAddr2_q <= latAddr2_d;
      latTt_q <= latTt_d;
      latBurstN_q <= latBurstN_d;
      latSize_q <= latSize_d;
      drvAddr_q <= drvAddr_d;
      drvPar_q <= drvPar_d; // [RL21]
      tsN_q <= tsN_d;
      xatsN_q <= xatsN_d;
      abbN_q <= abbN_d;
      oe_q <= oe_d;
      taken_q <= taken_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // snoop decode, sampled only in the strobe cycle of another master
  assign memHit = !bus.memoryStartStrobeN && !oe_q && !bus.transferTypeCode[0] &&
                  !bus.transferTypeCode[3] && !bus.transferTypeCode[4]; // [RL18] [RL20]
  assign dsHit = !bus.directStoreStartStrobeN && !oe_q &&
                 bus.transferTypeCode[0:3] == `APT_REPLY_TT &&
                 bus.addressBus[`APT_TAG_POS +: `APT_TAG_W] == processorTag; // [RL1]
  assign detect = (memHit || dsHit) && (|parBad); // [RL9] [RL6]
  assign apeReq = detect && !(strictVariant && !parityCheckEn); // [RL10]
  assign excReq = detect && parityCheckEn;

  always_comb begin
    snValid_d = memHit || dsHit;
    snDirect_d = snDirect_q;
    snRead_d = snRead_q;
    snAddrOnly_d = snAddrOnly_q;
    snAddr_d = snAddr_q;
    snTt_d = snTt_q;
    snXatc_d = snXatc_q;
    if (memHit || dsHit) begin
      snDirect_d = dsHit;
      snAddr_d = bus.addressBus; // [RL20] [RL1]
      snTt_d = bus.transferTypeCode; // [RL6]
      snRead_d = bus.transferTypeCode[1]; // [RL14]
      snAddrOnly_d = !bus.transferTypeCode[3]; // [RL14] [RL18]
    end
    if (dsHit) begin
      snXatc_d = {bus.transferTypeCode[0:3], bus.burstIndicatorN,
                  bus.transferSizeCode}; // [RL15] [RL17]
    end
    // error low one cycle, second after strobe
    apePipe_d = {apePipe_q[`APT_APE_ASSERT_DLY-2:0], apeReq}; // [RL12] [RL13]
    excPend_d = excReq;
    checkstop_d = checkstop_q || (excPend_q && (strictVariant || !machineCheckEnable)); // [RL7] [RL8]
    mc_d = excPend_q && !strictVariant && machineCheckEnable; // [RL7]
  end

  // snoop and error registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {snValid_q, snDirect_q, snRead_q, snAddrOnly_q, snTt_q, snXatc_q} <= '0;
      {apePipe_q, excPend_q, checkstop_q, mc_q} <= '0;
      snAddr_q <= `APT_ADDR_RST;
    end else begin
      snValid_q <= snValid_d;
      snDirect_q <= snDirect_d;
      snRead_q <= snRead_d;
      snAddrOnly_q <= snAddrOnly_d;
      snAddr_q <= snAddr_d;
      snTt_q <= snTt_d;
      snXatc_q <= snXatc_d;
      apePipe_q <= apePipe_d;
      excPend_q <= excPend_d;
      checkstop_q <= checkstop_d;
      mc_q <= mc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign bus.procAddr = drvAddr_q;
  assign bus.procPar = drvPar_q;
  assign bus.procTt = latTt_q;
  assign bus.procBurstN = latBurstN_q;
  assign bus.procSize = latSize_q;
  assign bus.procTsN = tsN_q;
  assign bus.procXatsN = xatsN_q;
  assign bus.procAbbN = abbN_q;
  assign bus.procOe = oe_q; // [RL5]
  assign bus.procApeOe = apePipe_q[`APT_APE_ASSERT_DLY-1]; // [RL11]
  assign reqTaken = taken_q;
  assign tenureDone = done_q;
  assign snoopValid = snValid_q;
  assign snoopDirect = snDirect_q;
  assign snoopRead = snRead_q;
  assign snoopAddrOnly = snAddrOnly_q;
  assign snoopAddr = snAddr_q;
  assign snoopTt = snTt_q;
  assign snoopXatc = snXatc_q;
  assign checkstop = checkstop_q;
  assign machineCheck = mc_q;
endmodule
`default_nettype wire

// ---- logic/apt_cfg.svh ----
// constants shared by both ends of the address tenure logic
`ifndef APT_CFG_SVH
`define APT_CFG_SVH
`define APT_ADDR_W 32
`define APT_BYTE_W 8
`define APT_PAR_W 4
`define APT_TT_W 5
`define APT_SIZE_W 3
`define APT_EXTENDED_TRANSFER_CODE_W 8
`define APT_TAG_W 4
`define APT_TAG_POS 28
`define APT_REPLY_TT 4'h8
`define APT_TT4_NEGATED 1'h0
`define APT_APE_ASSERT_DLY 2
`define APT_ADDR_RST 32'h00000000
`endif

// ---- logic/apt_pkg.sv ----
// state types for both ends of the address tenure logic
`default_nettype none
package apt_pkg;
  typedef enum logic [2:0] {
    MST_IDLE = 3'b000,
    MST_WAIT = 3'b001,
    MST_BEAT1 = 3'b010,
    MST_BEAT2 = 3'b011,
    MST_HOLD = 3'b100
  } apt_mst_state_type;
  typedef enum logic [1:0] {
    SYS_IDLE = 2'b00,
    SYS_BEAT1 = 2'b01,
    SYS_BEAT2 = 2'b10
  } apt_sys_state_type;
endpackage
`default_nettype wire

// ---- logic/apt_bus_if.sv ----
// address tenure wires between the processor end and the system end
`timescale 1ns/10ps
`default_nettype none
`include "apt_cfg.svh"
interface apt_bus_if;
  // processor drivers
  logic [0:`APT_ADDR_W-1] procAddr;
  logic [0:`APT_PAR_W-1] procPar;
  logic [0:`APT_TT_W-1] procTt;
  logic procBurstN;
  logic [0:`APT_SIZE_W-1] procSize;
  logic procTsN, procXatsN, procAbbN, procOe, procApeOe;
  // system end drivers
  logic [0:`APT_ADDR_W-1] sysAddr;
  logic [0:`APT_PAR_W-1] sysPar;
  logic [0:`APT_TT_W-1] sysTt;
  logic sysBurstN;
  logic [0:`APT_SIZE_W-1] sysSize;
  logic sysTsN, sysXatsN, sysAbbN, sysOe;
  logic busGrantN, addressAcknowledgeN;
  // resolved bus levels, released lines read high
  logic [0:`APT_ADDR_W-1] addressBus;
  logic [0:`APT_PAR_W-1] addressByteParity;
  logic [0:`APT_TT_W-1] transferTypeCode;
  logic burstIndicatorN;
  logic [0:`APT_SIZE_W-1] transferSizeCode;
  logic memoryStartStrobeN, directStoreStartStrobeN, addressBusyN, addressParityErrorN;
  // wire resolution from the enables
  assign addressBus = procOe ? procAddr : (sysOe ? sysAddr : '1);
  assign addressByteParity = procOe ? procPar : (sysOe ? sysPar : '1);
  assign transferTypeCode = procOe ? procTt : (sysOe ? sysTt : '1);
  assign burstIndicatorN = procOe ? procBurstN : (sysOe ? sysBurstN : 1'b1);
  assign transferSizeCode = procOe ? procSize : (sysOe ? sysSize : '1);
  assign memoryStartStrobeN = procOe ? procTsN : (sysOe ? sysTsN : 1'b1);
  assign directStoreStartStrobeN = procOe ? procXatsN : (sysOe ? sysXatsN : 1'b1);
  assign addressBusyN = procOe ? procAbbN : (sysOe ? sysAbbN : 1'b1);
  assign addressParityErrorN = procApeOe ? 1'b0 : 1'b1;
  modport proc (
    output procAddr, procPar, procTt, procBurstN, procSize,
    output procTsN, procXatsN, procAbbN, procOe, procApeOe,
    input busGrantN, addressAcknowledgeN, addressBus, addressByteParity,
    input transferTypeCode, burstIndicatorN, transferSizeCode,
    input memoryStartStrobeN, directStoreStartStrobeN, addressBusyN
  );
  modport sys (
    output sysAddr, sysPar, sysTt, sysBurstN, sysSize,
    output sysTsN, sysXatsN, sysAbbN, sysOe, busGrantN, addressAcknowledgeN,
    input procOe, addressBus, addressByteParity, transferTypeCode, burstIndicatorN,
    input transferSizeCode, memoryStartStrobeN, directStoreStartStrobeN,
    input addressBusyN, addressParityErrorN
  );
endinterface
`default_nettype wire

// ---- logic/apt_sys_end.sv ----
// system end: grant, acknowledge, own address tenures and checks of the processor
`timescale 1ns/10ps
`default_nettype none
`include "apt_cfg.svh"
module apt_sys_end (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // bus side
  apt_bus_if.sys bus,
  // arbitration
  input wire logic grantReq,
  // own tenure request
  input wire logic startValid,
  input wire logic startDirect,
  input wire logic [0:`APT_ADDR_W-1] startAddr,
  input wire logic [0:`APT_ADDR_W-1] startAddr2,
  input wire logic [0:`APT_TT_W-1] startTt,
  input wire logic startBurstN,
  input wire logic [0:`APT_SIZE_W-1] startSize,
  output logic startTaken,
  // observed processor tenures
  output logic seenValid,
  output logic seenDirect,
  output logic [0:`APT_ADDR_W-1] seenAddr,
  output logic [0:`APT_ADDR_W-1] seenAddr2,
  output logic [0:`APT_EXTENDED_TRANSFER_CODE_W-1] seenXatc,
  output logic seenParErr,
  output logic apeSeen
);
  apt_pkg::apt_sys_state_type st_q, st_d;
  logic [0:`APT_ADDR_W-1] addr_q, addr_d, addr2_q, addr2_d, sAddr_q, sAddr_d, sAddr2_q, sAddr2_d;
  logic [0:`APT_PAR_W-1] par_q, par_d, parBad;
  logic [0:`APT_TT_W-1] tt_q, tt_d;
  logic [0:`APT_SIZE_W-1] size_q, size_d;
  logic [0:`APT_EXTENDED_TRANSFER_CODE_W-1] sXatc_q, sXatc_d;
  logic burstN_q, burstN_d, direct_q, direct_d, tsN_q, tsN_d, xatsN_q, xatsN_d;
  logic abbN_q, abbN_d, oe_q, oe_d, taken_q, taken_d, grantN_q, grantN_d;
  logic aackN_q, aackN_d, dsPend_q, dsPend_d, sValid_q, sValid_d, sDirect_q, sDirect_d;
  logic sParErr_q, sParErr_d, ape_q, ape_d, busIdle, procMem, procDs;

  ////////////////////////////////////////////////////////////////////////////
  // per-byte odd parity out and check of the processor's parity
  genvar gi;
  generate
    for (gi = 0; gi < `APT_PAR_W; gi++) begin : gByte
      assign par_d[gi] = ~^addr_d[gi*`APT_BYTE_W +: `APT_BYTE_W]; // [RL3] [RL4]
      assign parBad[gi] = ~^{bus.addressBus[gi*`APT_BYTE_W +: `APT_BYTE_W],
                             bus.addressByteParity[gi]};
    end
  endgenerate

  assign busIdle = bus.addressBusyN && bus.memoryStartStrobeN && bus.directStoreStartStrobeN &&
                   !oe_q && !dsPend_q && aackN_q;
  assign procMem = !bus.memoryStartStrobeN && !oe_q;
  assign procDs = !bus.directStoreStartStrobeN && !oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // next values of all system end state except the parity bits
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    addr2_d = addr2_q;
    tt_d = tt_q;
    size_d = size_q;
    burstN_d = burstN_q;
    direct_d = direct_q;
    tsN_d = 1'b1;
    xatsN_d = 1'b1;
    abbN_d = abbN_q;
    oe_d = oe_q;
    taken_d = 1'b0;
    grantN_d = !(grantReq && busIdle && st_q == apt_pkg::SYS_IDLE);
    aackN_d = !(procMem || dsPend_q);
    dsPend_d = procDs;
    sValid_d = procMem || dsPend_q;
    sDirect_d = sDirect_q;
    sAddr_d = sAddr_q;
    sAddr2_d = sAddr2_q;
    sXatc_d = sXatc_q;
    sParErr_d = (procMem || procDs || dsPend_q) && (|parBad);
    ape_d = !bus.addressParityErrorN;
    if (procMem || procDs) begin
      sDirect_d = procDs;
      sAddr_d = bus.addressBus; // [RL20] [RL6]
      sXatc_d = {bus.transferTypeCode[0:3], bus.burstIndicatorN, bus.transferSizeCode}; // [RL15]
    end
    if (dsPend_q) begin
      sAddr2_d = bus.addressBus; // [RL2]
    end
    case (st_q)
      apt_pkg::SYS_IDLE: begin
        if (startValid && grantN_q && !grantReq && busIdle) begin
          addr_d = startAddr; // [RL6]
          addr2_d = startAddr2;
          tt_d = startTt;
          size_d = startSize;
          burstN_d = startBurstN;
          direct_d = startDirect;
          tsN_d = startDirect;
          xatsN_d = !startDirect; // [RL2]
          abbN_d = 1'b0;
          oe_d = 1'b1;
          taken_d = 1'b1;
          st_d = apt_pkg::SYS_BEAT1;
        end
      end
      apt_pkg::SYS_BEAT1: begin
        if (direct_q) begin
          addr_d = addr2_q; // [RL2]
          st_d = apt_pkg::SYS_BEAT2;
        end else begin
          oe_d = 1'b0;
          abbN_d = 1'b1;
          st_d = apt_pkg::SYS_IDLE;
        end
      end
      apt_pkg::SYS_BEAT2: begin
        oe_d = 1'b0;
        abbN_d = 1'b1;
        st_d = apt_pkg::SYS_IDLE;
      end
      default: begin
        oe_d = 1'b0;
        abbN_d = 1'b1;
        st_d = apt_pkg::SYS_IDLE;
      end
    endcase
  end

  // registers of the system end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= apt_pkg::SYS_IDLE;
      {addr_q, addr2_q, sAddr_q, sAddr2_q} <= {4{`APT_ADDR_RST}};
      {tt_q, size_q, direct_q, oe_q, taken_q, dsPend_q, sValid_q, sDirect_q} <= '0;
      {sXatc_q, sParErr_q, ape_q} <= '0;
      {par_q, burstN_q, tsN_q, xatsN_q, abbN_q, grantN_q, aackN_q} <= '1;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      addr2_q <= addr2_d;
      par_q <= par_d;
      tt_q <= tt_d;
      size_q <= size_d;
      burstN_q <= burstN_d;
      direct_q <= direct_d;
      tsN_q <= tsN_d;
      xatsN_q <= xatsN_d;
      abbN_q <= abbN_d;
      oe_q <= oe_d;
      taken_q <= taken_d;
      grantN_q <= grantN_d;
      aackN_q <= aackN_d;
      dsPend_q <= dsPend_d;
      sValid_q <= sValid_d;
      sDirect_q <= sDirect_d;
      sAddr_q <= sAddr_d;
      sAddr2_q <= sAddr2_d;
      sXatc_q <= sXatc_d;
      sParErr_q <= sParErr_d;
      ape_q <= ape_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign bus.sysAddr = addr_q;
  assign bus.sysPar = par_q;
  assign bus.sysTt = tt_q;
  assign bus.sysBurstN = burstN_q;
  assign bus.sysSize = size_q;
  assign bus.sysTsN = tsN_q;
  assign bus.sysXatsN = xatsN_q;
  assign bus.sysAbbN = abbN_q;
  assign bus.sysOe = oe_q;
  assign bus.busGrantN = grantN_q;
  assign bus.addressAcknowledgeN = aackN_q;
  assign startTaken = taken_q;
  assign seenValid = sValid_q;
  assign seenDirect = sDirect_q;
  assign seenAddr = sAddr_q;
  assign seenAddr2 = sAddr2_q;
  assign seenXatc = sXatc_q;
  assign seenParErr = sParErr_q;
  assign apeSeen = ape_q;
endmodule
`default_nettype wire

// ---- verification/apt_props.sv ----
// assertions on the processor side of the joined address tenure bus
`timescale 1ns/10ps
`default_nettype none
`include "apt_cfg.svh"
module apt_props (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // processor drivers
  input wire logic procOe,
  input wire logic procTsN,
  input wire logic procXatsN,
  input wire logic procAbbN,
  input wire logic [0:`APT_TT_W-1] procTt,
  // system end and resolved lines
  input wire logic busGrantN,
  input wire logic addressAcknowledgeN,
  input wire logic addressBusyN,
  input wire logic [0:`APT_ADDR_W-1] addressBus,
  input wire logic [0:`APT_PAR_W-1] addressByteParity,
  input wire logic memoryStartStrobeN,
  input wire logic directStoreStartStrobeN,
  input wire logic addressParityErrorN
);
  ////////////////////////////////////////////////////////////////////////////
  // odd count in every byte together with its parity bit
  function automatic logic parOk(input logic [0:31] a, input logic [0:3] p);
    parOk = ^{a[0:7], p[0]} & ^{a[8:15], p[1]} & ^{a[16:23], p[2]} & ^{a[24:31], p[3]};
  endfunction
  logic snoopBad;
  // a foreign strobe with bad parity on the bus
  assign snoopBad = !procOe && !(memoryStartStrobeN && directStoreStartStrobeN)
    && !parOk(addressBus, addressByteParity);
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_par_odd: assert property (procOe |-> parOk(addressBus, addressByteParity))
    else $error("bad parity");
  a_ape_cause: assert property (addressParityErrorN || $past(snoopBad, 2))
    else $error("false error");
  a_grant_drive: assert property ($rose(procOe) |->
    !$past(busGrantN) && $past(addressBusyN))
    else $error("no grant");
  a_drive_strobe: assert property ($rose(procOe) |->
    (procTsN ^ procXatsN) && !procAbbN)
    else $error("no strobe");
  a_strobe_once: assert property ($fell(procTsN) |=> procTsN && procOe)
    else $error("long strobe");
  a_ds_beats: assert property ($fell(procXatsN) |=>
    procOe && procXatsN && $stable(procTt))
    else $error("no beat2");
  a_float_ack: assert property (!addressAcknowledgeN && procOe && procTsN && procXatsN |=>
    !procOe && procAbbN)
    else $error("no float");
  a_tt_stable: assert property (procOe && $past(procOe) |-> $stable(procTt))
    else $error("type moved");
  // main scenarios
  c_mem: cover property (!procTsN && procOe);
  c_ds: cover property (!procXatsN && procOe);
  c_snoop: cover property (!memoryStartStrobeN && !procOe);
endmodule
`default_nettype wire

// ---- verification/address_parity_transfer_type_tb.sv ----
// testbench of both ends plus a faulty second bus
`timescale 1ns/10ps
`default_nettype none
module address_parity_transfer_type_tb;
  logic mclk, arst_n, reqValid, reqDirect, reqBurstN, reqTaken, tenureDone, grantReq;
  logic parityCheckEn, machineCheckEnable, strictVariant, snoopValid, snoopRead, snoopAddrOnly;
  logic startValid, startTaken, seenValid, seenDirect, sv2, cs2, mc2, csExp, cs1, mc1, pe1, ap1;
  logic [0:31] reqAddr, reqAddr2, snoopAddr, startAddr, seenAddr, seenAddr2;
  logic [0:4] reqTt, snoopTt, startTt;
  logic [0:2] reqSize;
  logic [0:3] processorTag;
  logic [0:7] seenXatc, x2;
  logic [0:72] e1, q1 [$];
  logic [0:38] e2, q2 [$];
  logic [0:10] e3, q3 [$];
  logic [2:0] cfgTab [5] = '{3'h6, 3'h2, 3'h3, 3'h4, 3'h7};
  int seed, cycles, numErrors, nTests;
  ////////////////////////////////////////////////////////////////////////////
  apt_bus_if bus ();
  apt_bus_if bus2 ();
  apt_proc_end u_apt_proc_end (.mclk, .arst_n, .bus(bus), .reqValid, .reqDirect, .reqAddr,
    .reqAddr2, .reqTt, .reqBurstN, .reqSize, .reqTaken, .tenureDone, .parityCheckEn,
    .machineCheckEnable, .strictVariant, .processorTag, .snoopValid, .snoopDirect(), .snoopRead,
    .snoopAddrOnly, .snoopAddr, .snoopTt, .snoopXatc(), .checkstop(cs1), .machineCheck(mc1));
  apt_proc_end u_apt_proc_end_2 (.mclk, .arst_n, .bus(bus2), .reqValid(1'h0), .reqDirect,
    .reqAddr, .reqAddr2, .reqTt, .reqBurstN, .reqSize, .reqTaken(), .tenureDone(),
    .parityCheckEn, .machineCheckEnable, .strictVariant, .processorTag, .snoopValid(sv2),
    .snoopDirect(), .snoopRead(), .snoopAddrOnly(), .snoopAddr(), .snoopTt(), .snoopXatc(x2),
    .checkstop(cs2), .machineCheck(mc2));
  apt_sys_end u_apt_sys_end (.mclk, .arst_n, .bus(bus), .grantReq, .startValid,
    .startDirect(1'h0), .startAddr, .startAddr2(reqAddr2), .startTt, .startBurstN(reqBurstN),
    .startSize(reqSize), .startTaken, .seenValid, .seenDirect, .seenAddr, .seenAddr2, .seenXatc,
    .seenParErr(pe1), .apeSeen(ap1));
  apt_props u_apt_props (.mclk, .arst_n, .procOe(bus.procOe), .procTsN(bus.procTsN),
    .procXatsN(bus.procXatsN), .procAbbN(bus.procAbbN), .procTt(bus.procTt),
    .busGrantN(bus.busGrantN), .addressAcknowledgeN(bus.addressAcknowledgeN),
    .addressBusyN(bus.addressBusyN), .addressBus(bus.addressBus),
    .addressByteParity(bus.addressByteParity), .memoryStartStrobeN(bus.memoryStartStrobeN),
    .directStoreStartStrobeN(bus.directStoreStartStrobeN),
    .addressParityErrorN(bus.addressParityErrorN));
  ////////////////////////////////////////////////////////////////////////////
  // odd parity per address byte
  function automatic logic [0:3] par(input logic [0:31] a);
    return {~^a[0:7], ~^a[8:15], ~^a[16:23], ~^a[24:31]};
  endfunction
  task chk(input logic [0:72] got, input logic [0:72] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (numErrors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task rst;
    arst_n <= 1'h0;
    cyc(6);
    arst_n <= 1'h1;
    csExp = 1'h0;
    cyc(1);
  endtask
  // processor master tenure, checked at the system end
  task mst(input logic ds);
    logic [0:31] a, b;
    logic [0:4] t;
    logic [0:3] s;
    a = $random(seed);
    b = $random(seed);
    t = 5'($random(seed));
    s = 4'($random(seed));
    {reqDirect, reqAddr, reqAddr2, reqTt, reqBurstN, reqSize} <= {ds, a, b, t, s};
    reqValid <= 1'h1;
    q1.push_back({ds, a, b, t[0:3], s});
    cyc(1);
    reqValid <= 1'h0;
    for (int i = 0; i < 20 && tenureDone !== 1'h1; i++) @(negedge mclk);
    @(posedge mclk);
  endtask
  // system end tenure snooped by the processor
  task sysT(input logic [0:4] t);
    logic [0:31] a;
    a = $random(seed);
    startAddr <= a;
    startTt <= t;
    startValid <= 1'h1;
    if (t[0] == 1'h0 && t[3] == 1'h0 && t[4] == 1'h0) q2.push_back({a, t, t[1], !t[3]});
    for (int i = 0; i < 20 && startTaken !== 1'h1; i++) @(negedge mclk);
    @(posedge mclk);
    startValid <= 1'h0;
    cyc(4);
  endtask
  // foreign direct-store tenure on the second bus, parity bits of bad bytes flipped by mask
  task ds2(input logic [0:3] tg, input logic [0:3] op, input logic [0:3] bad);
    logic [0:31] a;
    logic [0:3] s;
    logic err;
    a = $random(seed);
    a[28:31] = tg;
    s = 4'($random(seed));
    err = op === 4'h8 && tg === processorTag && bad !== 4'h0;
    if (err && parityCheckEn && (strictVariant || !machineCheckEnable)) csExp = 1'h1;
    if (op === 4'h8 && tg === processorTag) q3.push_back({op, s, err && !(strictVariant
      && !parityCheckEn), err && parityCheckEn && machineCheckEnable && !strictVariant, csExp});
    {bus2.sysOe, bus2.sysAbbN, bus2.sysXatsN, bus2.sysAddr} <= {3'h4, a};
    {bus2.sysPar, bus2.sysTt, bus2.sysBurstN, bus2.sysSize} <= {par(a) ^ bad, op, 1'h0, s};
    cyc(1);
    bus2.sysXatsN <= 1'h1;
    bus2.sysAddr <= ~a;
    bus2.sysPar <= ~par(~a);
    cyc(1);
    {bus2.sysOe, bus2.sysAbbN} <= 2'h1;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // result watchers on both ends
  always @(negedge mclk) begin
    chk(73'({cs1, mc1, pe1, ap1}), 73'(0));
    if (seenValid === 1'h1) begin
      e1 = q1.size() ? q1.pop_front() : 'x;
      chk(73'({seenDirect, seenAddr}), 73'(e1[0:32]));
      if (e1[0]) chk(73'({seenAddr2, seenXatc}), 73'(e1[33:72]));
    end
    if (snoopValid === 1'h1) begin
      e2 = q2.size() ? q2.pop_front() : 'x;
      chk(73'({snoopAddr, snoopTt, snoopRead, snoopAddrOnly}), 73'(e2));
    end
  end
  initial forever begin
    @(negedge mclk);
    if (sv2 === 1'h1) begin
      e3 = q3.size() ? q3.pop_front() : 'x;
      chk(73'(x2), 73'(e3[0:7]));
      @(negedge mclk);
      chk(73'({!bus2.addressParityErrorN, mc2, cs2}), 73'(e3[8:10]));
    end
    else chk(73'(bus2.addressParityErrorN), 73'(1'h1));
  end
  // clock and hang guard
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 89823;
    {arst_n, reqValid, startValid, grantReq, reqDirect, reqBurstN, reqSize} = 10'h10;
    {parityCheckEn, machineCheckEnable, strictVariant, reqAddr, reqAddr2} = 67'h0;
    {reqTt, startTt, startAddr, processorTag} = {42'h0, 4'($random(seed))};
    {bus2.sysOe, bus2.sysTsN, bus2.busGrantN, bus2.addressAcknowledgeN} = 4'h7;
    rst();
    grantReq <= 1'h1;
    repeat (6) mst(1'($random(seed)));
    grantReq <= 1'h0;
    cyc(4);
    sysT(5'h00);
    sysT(5'h04);
    sysT(5'h08);
    sysT(5'h0C);
    sysT(5'h0A);
    sysT(5'h1C);
    {parityCheckEn, machineCheckEnable, strictVariant} <= 3'h6;
    cyc(1);
    ds2(processorTag, 4'h8, 4'h0);
    ds2(processorTag ^ 4'h1, 4'h8, 4'h3);
    ds2(processorTag, 4'h9, 4'h2);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) rst();
      {parityCheckEn, machineCheckEnable, strictVariant} <= cfgTab[i];
      cyc(1);
      ds2(processorTag, 4'h8, 4'h1 << (i % 4));
    end
    cyc(4);
    chk(73'(q1.size() + q2.size() + q3.size()), 73'(0));
    conclude();
  end
endmodule
`default_nettype wire
